//--- rtl/cip_pkg.sv
/*
  Shared constants for the continuous interpolation pre-buffer: register
  offsets, command codes, field positions and AXI4-Lite response codes.
  Assumes a 32-bit AXI4-Lite register bus with byte offsets below 256.
*/
package cip_pkg;
  // Pre-buffer shape.
  localparam int CIP_DEPTH = 8;
  localparam int CIP_CODE_W = 8;
  localparam int CIP_AXES = 4;
  localparam int CIP_CNT_W = 4;

  // Register byte offsets.
  localparam logic [7:0] CIP_OFF_CMD = 8'h00;
  localparam logic [7:0] CIP_OFF_PARAM = 8'h04;
  localparam logic [7:0] CIP_OFF_STATUS = 8'h08;
  localparam logic [7:0] CIP_OFF_ERR = 8'h0c;
  localparam logic [7:0] CIP_OFF_MODE = 8'h10;

  // Command codes, written to the low byte of the command register.
  localparam logic [7:0] CIP_CMD_MODE = 8'h2a;
  localparam logic [7:0] CIP_CMD_HOLD = 8'h77;
  localparam logic [7:0] CIP_CMD_RELEASE = 8'h78;
  localparam logic [7:0] CIP_CMD_CLEAR = 8'h79;
  localparam logic [7:0] CIP_CMD_IRQ_CLR = 8'h6f;
  localparam logic [7:0] CIP_CMD_STOP = 8'h26;
  localparam logic [7:0] CIP_CMD_DRV_LO = 8'h61;
  localparam logic [7:0] CIP_CMD_DRV_HI = 8'h65;

  // Command register fields.
  localparam int CIP_CMD_AXIS_LSB = 8;

  // Mode word fields.
  localparam int CIP_MODE_HALF_BIT = 14;
  localparam int CIP_MODE_ONE_BIT = 15;

  // Status and error word fields.
  localparam int CIP_ST_RUN_BIT = 0;
  localparam int CIP_ST_ERR_LSB = 4;
  localparam int CIP_ST_NEXT_BIT = 11;
  localparam int CIP_ST_CNT_LSB = 12;
  localparam int CIP_ERR_INTERP_BIT = 7;

  // Stack counts that matter.
  localparam logic [3:0] CIP_CNT_EMPTY = 4'h0;
  localparam logic [3:0] CIP_CNT_ONE = 4'h1;
  localparam logic [3:0] CIP_CNT_FULL = 4'h8;
  localparam logic [3:0] CIP_CNT_LAST_FREE = 4'h7;
  localparam logic [3:0] CIP_CNT_HALF_FROM = 4'h4;
  localparam logic [3:0] CIP_CNT_HALF_TO = 4'h3;

  // AXI responses.
  localparam logic [1:0] CIP_RESP_OKAY = 2'h0;
  localparam logic [1:0] CIP_RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    CIP_IDLE,
    CIP_HOLD,
    CIP_RUN
  } cip_state_t;
endpackage

//--- rtl/cip_stack.sv
/*
  Segment stack: a first-in first-out store of queued driving commands
  kept in flip-flops, with push, pop, flush and an occupancy count.
  Assumes the caller never pushes when full nor pops when empty.
*/
`timescale 1ns/1ps
module cip_stack import cip_pkg::*; #(
  parameter int WIDTH = CIP_CODE_W,
  parameter int DEPTH = CIP_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  input wire logic flush,
  output logic [WIDTH-1:0] head_data,
  output logic [CIP_CNT_W-1:0] count
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [PTR_W-1:0] rd_ptr, wr_ptr, next_rd_ptr, next_wr_ptr;
  logic [CIP_CNT_W-1:0] next_count;

  assign head_data = mem[rd_ptr];

  ////////////////////////////////////////////////////////////////////////
  // Pointer and count update; a flush beats everything else.
  always_comb begin
    next_mem = mem;
    next_rd_ptr = rd_ptr;
    next_wr_ptr = wr_ptr;
    next_count = count;
    if (flush) begin
      next_rd_ptr = '0;
      next_wr_ptr = '0;
      next_count = '0;
    end else begin
      if (push) begin
        next_mem[wr_ptr] = push_data;
        next_wr_ptr = PTR_W'(wr_ptr + 1'b1);
      end
      if (pop) begin
        next_rd_ptr = PTR_W'(rd_ptr + 1'b1);
      end
      // A push and a pop in one cycle leave the count alone.
      if (push && !pop) begin
        next_count = CIP_CNT_W'(count + 1'b1);
      end else if (pop && !push) begin
        next_count = CIP_CNT_W'(count - 1'b1);
      end
    end
  end

  // Registers only; the storage needs no reset but gets one for clean reads.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
      rd_ptr <= '0;
      wr_ptr <= '0;
      count <= '0;
    end else begin
      mem <= next_mem;
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      count <= next_count;
    end
  end
endmodule

//--- rtl/cip_prebuffer_ctrl.sv
/*
  Continuous interpolation pre-buffer control with an AXI4-Lite slave.
  Software writes command parameters and commands; queued driving
  commands pass to the interpolation engine one segment at a time.
  Assumes the engine pulses seg_done when a segment ends, holds seg_tail
  high once the last pulse of the current segment has fallen, and pulses
  limit_err per axis on a limit-type fault.
*/
// Operation
// - Eight-stage stack queues driving commands.
// - Mode word low nibble selects axes.
// - Hold-start queues commands without motion.
// - Hold-release starts queued segments.
// - Axis fault sets error bit, stops.
// - Status shows stack count, eight means full.
// - Count up on command, down on completion.
// - Next-writable flag for count one to seven, in run state only.
// - Interrupt low on free space, mode bits.
// - Half mode: interrupt on four to three.
// - One-free mode: interrupt on eight to seven.
// - Interrupt released by command, clear, completion.
// - Limit error empties stack, stops.
// - Late command skipped, error flagged, run ends.
// - Stop command discards queued segments.
`timescale 1ns/1ps
module cip_prebuffer_ctrl import cip_pkg::*; #(
  parameter int ADDR_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic seg_done,
  input wire logic seg_tail,
  input wire logic [CIP_AXES-1:0] limit_err,
  output logic seg_start,
  output logic [CIP_CODE_W-1:0] seg_code,
  output logic [CIP_AXES-1:0] interp_axes,
  output logic drive_stop,
  output logic segment_irq_n_out,
  output logic segment_irq_n_oe
);
  ////////////////////////////////////////////////////////////////////////
  // Bus slave state.
  logic aw_held, w_held, next_aw_held, next_w_held;
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic wr_go;

  // Control state.
  cip_state_t state, next_state;
  logic [15:0] command_parameter_low, next_param;
  logic [CIP_AXES-1:0] axis_error_flags, next_axis_err;
  logic interp_err, next_interp_err;
  logic half_empty_irq_enable, next_half_en;
  logic one_free_irq_enable, next_one_en;
  logic [CIP_AXES-1:0] next_axes;
  logic seg_busy, next_seg_busy;
  logic next_seg_start, next_drive_stop, next_irq;
  logic [CIP_CODE_W-1:0] next_seg_code;
  logic [CIP_CNT_W-1:0] cnt_prev;

  // Decoded command and stack hooks.
  logic cmd_wr, drv_cmd, drv_ok, late_wr, to_main, push, pop, flush;
  logic limit_hit, run_done, next_segment_writable;
  logic [7:0] cmd_code;
  logic [CIP_AXES-1:0] cmd_mask, main_bit;
  logic [CIP_CNT_W-1:0] prebuffer_stack_count;
  logic [CIP_CODE_W-1:0] head_code;
  logic [15:0] main_status;

  cip_stack #(
    .WIDTH(CIP_CODE_W),
    .DEPTH(CIP_DEPTH)
  ) u_stack (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .push(push),
    .push_data(cmd_code),
    .pop(pop),
    .flush(flush),
    .head_data(head_code),
    .count(prebuffer_stack_count)
  );

  ////////////////////////////////////////////////////////////////////////
  // Write channel: address and data are caught in either order, the
  // effect happens once both are held, and the response follows.
  assign wr_go = aw_held && w_held && !s_axi_bvalid;

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_go) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (aw_addr == CIP_OFF_CMD || aw_addr == CIP_OFF_PARAM) ?
                   CIP_RESP_OKAY : CIP_RESP_DECERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    // Ready stays low from capture until the response is taken.
    next_awready = !next_aw_held && !next_bvalid;
    next_wready = !next_w_held && !next_bvalid;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= CIP_RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read channel and status word; reads have no side effects.
  assign next_segment_writable = (state == CIP_RUN) &&
    (prebuffer_stack_count >= CIP_CNT_ONE) &&
    (prebuffer_stack_count <= CIP_CNT_LAST_FREE);

  always_comb begin
    main_status = '0;
    main_status[CIP_ST_RUN_BIT] = (state == CIP_RUN);
    main_status[CIP_ST_ERR_LSB +: CIP_AXES] = axis_error_flags;
    main_status[CIP_ST_NEXT_BIT] = next_segment_writable;
    main_status[CIP_ST_CNT_LSB +: CIP_CNT_W] = prebuffer_stack_count;
  end

  always_comb begin
    next_arready = s_axi_arready;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rresp = CIP_RESP_OKAY;
      next_rdata = '0;
      unique case (s_axi_araddr)
        CIP_OFF_CMD, CIP_OFF_PARAM: next_rdata = '0;
        CIP_OFF_STATUS: next_rdata[15:0] = main_status;
        CIP_OFF_ERR: next_rdata[CIP_ERR_INTERP_BIT] = interp_err;
        CIP_OFF_MODE: begin
          next_rdata[CIP_AXES-1:0] = interp_axes;
          next_rdata[CIP_MODE_HALF_BIT] = half_empty_irq_enable;
          next_rdata[CIP_MODE_ONE_BIT] = one_free_irq_enable;
        end
        default: next_rresp = CIP_RESP_DECERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= CIP_RESP_OKAY;
    end else begin
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command decode. The main axis is the lowest selected axis.
  assign cmd_wr = wr_go && aw_addr == CIP_OFF_CMD && (&w_strb[1:0]);
  assign cmd_code = w_data[7:0];
  assign cmd_mask = w_data[CIP_CMD_AXIS_LSB +: CIP_AXES];
  assign main_bit = interp_axes & (~interp_axes + 4'h1);
  assign to_main = |(cmd_mask & main_bit);
  assign drv_cmd = cmd_wr && cmd_code >= CIP_CMD_DRV_LO &&
                   cmd_code <= CIP_CMD_DRV_HI;
  // Commands arriving after the last pulse of the last segment are late.
  assign late_wr = drv_cmd && state == CIP_RUN && seg_busy && seg_tail &&
                   prebuffer_stack_count == CIP_CNT_ONE;
  // An axis with an error blocks all driving until it is cleared.
  assign drv_ok = drv_cmd && !late_wr && !interp_err &&
                  axis_error_flags == '0 &&
                  prebuffer_stack_count != CIP_CNT_FULL;
  assign limit_hit = state == CIP_RUN && |(limit_err & interp_axes);
  assign flush = limit_hit || late_wr ||
    (cmd_wr && cmd_code == CIP_CMD_STOP && state != CIP_IDLE);
  assign push = drv_ok && !flush;
  assign pop = seg_done && seg_busy && !flush;
  assign run_done = state == CIP_RUN && pop && !push &&
                    prebuffer_stack_count == CIP_CNT_ONE;

  ////////////////////////////////////////////////////////////////////////
  // Sequencing, errors, mode word and interrupt.
  always_comb begin
    next_state = state;
    next_param = command_parameter_low;
    next_axis_err = axis_error_flags;
    next_interp_err = interp_err;
    next_axes = interp_axes;
    next_half_en = half_empty_irq_enable;
    next_one_en = one_free_irq_enable;
    next_seg_busy = seg_busy;
    next_seg_start = 1'b0;
    next_seg_code = seg_code;
    next_drive_stop = flush;
    next_irq = segment_irq_n_oe;
    if (wr_go && aw_addr == CIP_OFF_PARAM) begin
      if (w_strb[0]) next_param[7:0] = w_data[7:0];
      if (w_strb[1]) next_param[15:8] = w_data[15:8];
    end
    // Axes and interrupt mode change only while no run is under way.
    if (cmd_wr && cmd_code == CIP_CMD_MODE && state == CIP_IDLE) begin
      next_axes = command_parameter_low[CIP_AXES-1:0];
      next_half_en = command_parameter_low[CIP_MODE_HALF_BIT];
      next_one_en = command_parameter_low[CIP_MODE_ONE_BIT];
    end
    if (cmd_wr && cmd_code == CIP_CMD_CLEAR) begin
      next_axis_err = axis_error_flags & ~cmd_mask;
      if ((cmd_mask & interp_axes) == interp_axes) begin
        next_interp_err = 1'b0;
      end
    end
    if (seg_done) begin
      next_seg_busy = 1'b0;
    end
    unique case (state)
      CIP_IDLE: begin
        if (cmd_wr && cmd_code == CIP_CMD_HOLD && to_main) begin
          next_state = CIP_HOLD;
        end else if (push) begin
          next_state = CIP_RUN;
        end
      end
      CIP_HOLD: begin
        if (flush) begin
          next_state = CIP_IDLE;
        end else if (cmd_wr && cmd_code == CIP_CMD_RELEASE && to_main) begin
          next_state = (prebuffer_stack_count != CIP_CNT_EMPTY || push) ?
                       CIP_RUN : CIP_IDLE;
        end
      end
      CIP_RUN: begin
        if (flush || run_done) begin
          next_state = CIP_IDLE;
        end else if (!seg_busy && prebuffer_stack_count != CIP_CNT_EMPTY) begin
          next_seg_start = 1'b1;
          next_seg_code = head_code;
          next_seg_busy = 1'b1;
        end
      end
    endcase
    if (limit_hit) begin
      next_axis_err = next_axis_err | (limit_err & interp_axes);
    end
    if (late_wr) begin
      next_interp_err = 1'b1;
    end
    if (flush) begin
      next_seg_busy = 1'b0;
    end
    // Release events first, so a new fall in the same cycle wins.
    if (drv_cmd || run_done ||
        (cmd_wr && cmd_code == CIP_CMD_IRQ_CLR)) begin
      next_irq = 1'b0;
    end
    if (half_empty_irq_enable && cnt_prev == CIP_CNT_HALF_FROM &&
        prebuffer_stack_count == CIP_CNT_HALF_TO) begin
      next_irq = 1'b1;
    end
    if (one_free_irq_enable && cnt_prev == CIP_CNT_FULL &&
        prebuffer_stack_count == CIP_CNT_LAST_FREE) begin
      next_irq = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= CIP_IDLE;
      command_parameter_low <= '0;
      axis_error_flags <= '0;
      interp_err <= 1'b0;
      interp_axes <= '0;
      half_empty_irq_enable <= 1'b0;
      one_free_irq_enable <= 1'b0;
      seg_busy <= 1'b0;
      seg_start <= 1'b0;
      seg_code <= '0;
      drive_stop <= 1'b0;
      segment_irq_n_oe <= 1'b0;
      cnt_prev <= '0;
    end else begin
      state <= next_state;
      command_parameter_low <= next_param;
      axis_error_flags <= next_axis_err;
      interp_err <= next_interp_err;
      interp_axes <= next_axes;
      half_empty_irq_enable <= next_half_en;
      one_free_irq_enable <= next_one_en;
      seg_busy <= next_seg_busy;
      seg_start <= next_seg_start;
      seg_code <= next_seg_code;
      drive_stop <= next_drive_stop;
      segment_irq_n_oe <= next_irq;
      cnt_prev <= prebuffer_stack_count;
    end
  end

  // The pin is open drain: it only ever pulls low.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      segment_irq_n_out <= 1'b0;
    end else begin
      segment_irq_n_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks on the stack and interrupt behaviour.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_half_fall;
    half_empty_irq_enable && cnt_prev == CIP_CNT_HALF_FROM &&
    prebuffer_stack_count == CIP_CNT_HALF_TO;
  endsequence

  sequence s_one_fall;
    one_free_irq_enable && cnt_prev == CIP_CNT_FULL &&
    prebuffer_stack_count == CIP_CNT_LAST_FREE;
  endsequence

  a_count_bound: assert property (
    prebuffer_stack_count <= CIP_CNT_FULL)
    else $error("stack count above full");
  a_push_counts: assert property (
    push && !pop |=> prebuffer_stack_count ==
      CIP_CNT_W'($past(prebuffer_stack_count) + 1'b1))
    else $error("accepted command did not count up");
  a_same_cycle: assert property (
    push && pop |=> $stable(prebuffer_stack_count))
    else $error("push with completion changed count");
  a_hold_queue: assert property (
    state == CIP_HOLD && push
      |=> state == CIP_HOLD && !seg_start)
    else $error("held run started motion");
  a_release_run: assert property (
    state == CIP_HOLD && cmd_wr && cmd_code == CIP_CMD_RELEASE && to_main &&
    !flush && prebuffer_stack_count != CIP_CNT_EMPTY
      |=> state == CIP_RUN ##1 seg_start)
    else $error("release did not start the queue");
  a_limit_flush: assert property (
    limit_hit |=> prebuffer_stack_count == CIP_CNT_EMPTY &&
      state == CIP_IDLE && drive_stop)
    else $error("limit error left segments queued");
  a_late_error: assert property (
    late_wr |=> interp_err && state == CIP_IDLE)
    else $error("late command not flagged");
  a_irq_half: assert property (
    s_half_fall |=> segment_irq_n_oe)
    else $error("half-empty interrupt missing");
  a_irq_one: assert property (
    s_one_fall |=> segment_irq_n_oe)
    else $error("one-free interrupt missing");
  a_next_flag: assert property (
    state == CIP_RUN && prebuffer_stack_count == CIP_CNT_FULL
      |-> !next_segment_writable &&
      main_status[CIP_ST_CNT_LSB +: CIP_CNT_W] == CIP_CNT_FULL)
    else $error("full stack reported writable");
endmodule

//--- testbench/cip_engine_model.sv
/*
  Behavioural interpolation engine that stands behind the pre-buffer.
  Assumes one segment at a time, started by a seg_start pulse.
*/
`timescale 1ns/1ps
module cip_engine_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic seg_start,
  input wire logic drive_stop,
  input wire logic auto_run,
  input wire logic step,
  input wire logic [7:0] dly,
  output logic seg_done,
  output logic seg_tail
);
  logic busy;
  logic [7:0] cnt;

  ////////////////////////////////////////////////////////////////////////
  // A segment outputs pulses for dly cycles and then waits in its tail.
  // A slow host is mimicked by holding the tail until step is given.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      cnt <= 8'h00;
    end else if (drive_stop || seg_done) begin
      busy <= 1'b0;
    end else if (seg_start) begin
      busy <= 1'b1;
      cnt <= 8'h00;
    end else if (busy && !seg_tail) begin
      cnt <= cnt + 8'h01;
    end
  end

  // The tail stays high until the segment is declared done.
  assign seg_tail = busy && (cnt >= dly);
  assign seg_done = seg_tail && (auto_run || step);
endmodule

//--- testbench/testbench.sv
/*
  Self-checking bench for the pre-buffer control and its register bus.
  Assumes the engine model above as the far side of the segment port.
*/
`timescale 1ns/1ps
module testbench import cip_pkg::*;;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} cip_row_t;
  logic ref_clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, seg_done, seg_tail, seg_start;
  logic drive_stop, irq_out, irq_oe, auto_run, step;
  logic [7:0] awaddr, araddr, seg_code, dly;
  logic [31:0] wdata, rdata, s;
  logic [1:0] bresp, rresp, r;
  logic [3:0] limit_err, axes;
  int failures, comparisons, starts, stops, ticks;
  cip_row_t rows [6];

  cip_prebuffer_ctrl cip_prebuffer_ctrl_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .seg_done(seg_done),
    .seg_tail(seg_tail), .limit_err(limit_err), .seg_start(seg_start),
    .seg_code(seg_code), .interp_axes(axes), .drive_stop(drive_stop),
    .segment_irq_n_out(irq_out), .segment_irq_n_oe(irq_oe));
  cip_engine_model cip_engine_model_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .seg_start(seg_start), .drive_stop(drive_stop), .auto_run(auto_run),
    .step(step), .dly(dly), .seg_done(seg_done), .seg_tail(seg_tail));

  ////////////////////////////////////////////////////////////////////////
  // Clock, pulse counters and the hang guard.
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    ticks++;
    if (seg_start === 1'b1) starts++;
    if (drive_stop === 1'b1) stops++;
    if (ticks == 20000) begin
      failures++;
      summarize();
    end
  end

  task automatic summarize;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Bus tasks: each channel is held until its own ready is sampled.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic cmd(input logic [7:0] c, input logic [3:0] m);
    wr(CIP_OFF_CMD, {20'h0, m, c});
  endtask

  task automatic stc(input logic [3:0] c, input logic nx);
    rd(CIP_OFF_STATUS, s);
    chk("count", 32'(c), 32'(s[15:12]));
    chk("next", 32'(nx), 32'(s[11]));
  endtask

  // Hold, then queue n segments cycling through all driving codes.
  task automatic load(input int n);
    cmd(CIP_CMD_HOLD, 4'h1);
    for (int i = 0; i < n; i++) cmd(CIP_CMD_DRV_LO + 8'(i % 5), 4'h1);
  endtask

  task automatic seg_step;
    wait (seg_tail === 1'b1);
    @(posedge ref_clk);
    step <= 1'b1;
    @(posedge ref_clk);
    step <= 1'b0;
    // Let the finished tail fall and the interrupt settle before moving on.
    repeat (3) @(posedge ref_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence: reset table, then the hand-written cases.
  initial begin
    {ref_clk, rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {auto_run, step, awaddr, araddr, wdata, limit_err} = '0;
    dly = 8'd6;
    rows = '{'{CIP_OFF_CMD, 0, 0}, '{CIP_OFF_PARAM, 0, 0},
      '{CIP_OFF_STATUS, 0, 0}, '{CIP_OFF_ERR, 0, 0},
      '{CIP_OFF_MODE, 0, 0}, '{8'h14, 0, CIP_RESP_DECERR}};
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    foreach (rows[i]) begin
      rd(rows[i].a, s);
      chk("rdata", rows[i].d, s);
      chk("rresp", 32'(rows[i].r), 32'(r));
    end
    $display("test reset done");
    wr(8'h14, 32'h0);
    chk("bresp", 32'(CIP_RESP_DECERR), 32'(bresp));
    wr(CIP_OFF_PARAM, 32'h4003);
    chk("bresp", 32'(CIP_RESP_OKAY), 32'(bresp));
    cmd(CIP_CMD_MODE, 4'h1);
    rd(CIP_OFF_MODE, s);
    chk("mode", 32'h4003, s);
    chk("axes", 32'h3, 32'(axes));
    load(8);
    stc(4'h8, 1'b0);
    chk("held", 0, starts);
    cmd(CIP_CMD_RELEASE, 4'h1);
    stc(4'h8, 1'b0);
    chk("started", 1, starts);
    chk("code", 32'(CIP_CMD_DRV_LO), 32'(seg_code));
    seg_step();
    stc(4'h7, 1'b1);
    chk("code2", 32'(CIP_CMD_DRV_LO + 8'h01), 32'(seg_code));
    repeat (3) seg_step();
    chk("irq_n", 0, 32'(irq_out));
    chk("irq4", 0, 32'(irq_oe));
    seg_step();
    stc(4'h3, 1'b1);
    chk("irq3", 1, 32'(irq_oe));
    cmd(CIP_CMD_DRV_HI, 4'h1);
    chk("irq_cmd", 0, 32'(irq_oe));
    stc(4'h4, 1'b1);
    seg_step();
    chk("irq_again", 1, 32'(irq_oe));
    cmd(CIP_CMD_IRQ_CLR, 4'h1);
    chk("irq_clr", 0, 32'(irq_oe));
    repeat (2) seg_step();
    wait (seg_tail === 1'b1);
    cmd(CIP_CMD_DRV_LO, 4'h1);
    rd(CIP_OFF_ERR, s);
    chk("late_err", 32'h80, s);
    stc(4'h0, 1'b0);
    chk("late_stop", 1, stops);
    cmd(CIP_CMD_CLEAR, 4'h3);
    rd(CIP_OFF_ERR, s);
    chk("err_clr", 0, s);
    $display("test queue done");
    auto_run <= 1'b1;
    dly <= 8'd40;
    load(3);
    cmd(CIP_CMD_RELEASE, 4'h1);
    @(posedge ref_clk);
    limit_err <= 4'h2;
    @(posedge ref_clk);
    limit_err <= 4'h0;
    stc(4'h0, 1'b0);
    chk("axis_err", 32'h2, 32'(s[7:4]));
    chk("lim_stop", 2, stops);
    cmd(CIP_CMD_CLEAR, 4'h3);
    load(3);
    cmd(CIP_CMD_RELEASE, 4'h1);
    cmd(CIP_CMD_STOP, 4'h1);
    stc(4'h0, 1'b0);
    chk("stop", 3, stops);
    $display("test errors done");
    auto_run <= 1'b0;
    dly <= 8'd2;
    wr(CIP_OFF_PARAM, 32'h8003);
    cmd(CIP_CMD_MODE, 4'h1);
    load(8);
    cmd(CIP_CMD_RELEASE, 4'h1);
    chk("irq8", 0, 32'(irq_oe));
    seg_step();
    stc(4'h7, 1'b1);
    chk("irq7", 1, 32'(irq_oe));
    cmd(CIP_CMD_STOP, 4'h1);
    $display("test one_free done");
    summarize();
  end
endmodule
